// File: include/dmc_pkg.sv
// Constants, register map and carrier types of the DMA channel enable and
// request mask control block.
// Assumes a 32-bit classic Wishbone slave port on the system clock.
//
// Summary of operation
// - Bit C of each mask and enable register maps channel C.
// - Mask clear write one unmasks channel C.
// - Mask clear write zero leaves mask unchanged.
// - Enable set read returns channel enable state.
// - Enable set write one enables channel C.
// - Enable clear write one disables channel C.
// - Enable clear read also returns enable state.
// - Completed DMA cycle disables its channel unless an enable set write of one to it lands in the same cycle.
// - After reset all channels disabled, registers zero.
// - Mask set write one masks; reads mask state.
// - Configuration bit zero gates the masked request outputs.
package dmc_pkg;

    // Number of DMA channels and the width of the bus data word.
    localparam int          DMC_CHANS        = 14;
    localparam int          DMC_DATA_W       = 32;

    // Register byte addresses on the system bus.
    localparam logic [31:0] DMC_ADR_CONFIG   = 32'h4001_0004;
    localparam logic [31:0] DMC_ADR_MASK_SET = 32'h4001_0020;
    localparam logic [31:0] DMC_ADR_MASK_CLR = 32'h4001_0024;
    localparam logic [31:0] DMC_ADR_EN_SET   = 32'h4001_0028;
    localparam logic [31:0] DMC_ADR_EN_CLR   = 32'h4001_002c;

    // Field positions and reset values.
    localparam int          DMC_CFG_EN_POS   = 0;
    localparam logic [31:0] DMC_RESET_WORD   = 32'h0000_0000;
    localparam logic [13:0] DMC_RESET_CHANS  = 14'h0000;

    // Per-channel write strobes decoded from one bus write.
    typedef struct packed {
        logic [13:0] mask_set;
        logic [13:0] mask_clr;
        logic [13:0] en_set;
        logic [13:0] en_clr;
    } dmc_strobe_s;

    // Bus slave and output state of the top module.
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] dat;
        logic        ctrl_enable;
        logic [13:0] masked_req;
    } dmc_top_s;

    // One set/clear channel bit.
    typedef struct packed {
        logic q;
    } dmc_bit_s;

    // Three-stage request synchroniser with agreement filter.
    typedef struct packed {
        logic [13:0] s1;
        logic [13:0] s2;
        logic [13:0] s3;
        logic [13:0] q;
    } dmc_sync_s;

endpackage

// File: rtl/dmc_chan_bit.sv
// One channel state bit with software set, software clear and hardware clear.
// Assumes the set and clear strobes never come from the same bus write.
`timescale 1ns/1ps
module dmc_chan_bit
    import dmc_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic set,
    input  wire logic clr,
    input  wire logic hw_clr,
    output logic      q
);

    dmc_bit_s st;
    dmc_bit_s next_st;

    // A software write overrides a completion clear in the same cycle.
    always_comb
    begin
        next_st = st;
        if (set)
        begin
            next_st.q = 1'b1;
        end
        else if (clr)
        begin
            next_st.q = 1'b0;
        end
        else if (hw_clr)
        begin
            next_st.q = 1'b0;
        end
    end

    // Every channel starts disabled and unmasked.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q = st.q;

    set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
        set |=> q)
        else $error("Set strobe did not raise the channel bit.");

    hw_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (hw_clr && !set) |=> !q)
        else $error("Completion did not clear the channel bit.");

endmodule

// File: rtl/dmc_ctrl.sv
// Top of the DMA channel enable and request mask control block.
// Assumes a classic Wishbone master on CLK_SYS, asynchronous peripheral
// request pins, and a transfer datapath on CLK_SYS that pulses CYCLE_DONE.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module dmc_ctrl
    import dmc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             WB_ERR_O,
    input  wire logic [13:0] PERIPH_REQ,
    input  wire logic [13:0] CYCLE_DONE,
    output logic      [13:0] CHAN_ENABLE,
    output logic      [13:0] MASKED_REQ,
    output logic             CTRL_ENABLE
);

    dmc_top_s    st;
    dmc_top_s    next_st;
    dmc_strobe_s stb;
    logic [13:0] req_level;
    logic [13:0] mask_q;
    logic [13:0] en_q;
    logic        access;
    logic        write_now;
    logic        mapped;
    logic [31:0] lane_mask;
    logic [31:0] wr_bits;

    // True when the bus address names the given register.
    function automatic logic hit(input logic [31:0] adr, input logic [31:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    // Value returned for a read of a given address; write-only words read zero.
    function automatic logic [31:0] read_word(input logic [31:0] adr,
                                              input logic [13:0] mask,
                                              input logic [13:0] en);
        read_word = DMC_RESET_WORD;
        if (hit(adr, DMC_ADR_MASK_SET))
        begin
            read_word[13:0] = mask;
        end
        else if (hit(adr, DMC_ADR_EN_SET))
        begin
            read_word[13:0] = en;
        end
        else if (hit(adr, DMC_ADR_EN_CLR))
        begin
            read_word[13:0] = en;
        end
    endfunction

    // Bus access decode. The write is applied on the edge at which the master
    // sees the acknowledge, so a write is never applied twice or early.
    assign access    = WB_CYC_I && WB_STB_I;
    assign write_now = access && WB_WE_I && st.ack;
    assign mapped    = hit(WB_ADR_I, DMC_ADR_CONFIG)   || hit(WB_ADR_I, DMC_ADR_MASK_SET) ||
                       hit(WB_ADR_I, DMC_ADR_MASK_CLR) || hit(WB_ADR_I, DMC_ADR_EN_SET) ||
                       hit(WB_ADR_I, DMC_ADR_EN_CLR);

    // Byte enables gate the write data lane by lane.
    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_lane
            assign lane_mask[8*b +: 8] = {8{WB_SEL_I[b]}};
        end
    endgenerate

    assign wr_bits = WB_DAT_I & lane_mask;

    // Per-channel strobes; the upper bits of a written word are dropped.
    always_comb
    begin
        stb = '0;
        if (write_now)
        begin
            if (hit(WB_ADR_I, DMC_ADR_MASK_SET))
            begin
                stb.mask_set = wr_bits[13:0];
            end
            if (hit(WB_ADR_I, DMC_ADR_MASK_CLR))
            begin
                stb.mask_clr = wr_bits[13:0];
            end
            if (hit(WB_ADR_I, DMC_ADR_EN_SET))
            begin
                stb.en_set = wr_bits[13:0];
            end
            if (hit(WB_ADR_I, DMC_ADR_EN_CLR))
            begin
                stb.en_clr = wr_bits[13:0];
            end
        end
    end

    // Peripheral request pins arrive from outside the clock domain.
    dmc_req_sync u_req_sync
    (
        .clk   (CLK_SYS),
        .nrst  (NRST),
        .pin   (PERIPH_REQ),
        .level (req_level)
    );

    // One mask bit and one enable bit per channel; a zero in a written word
    // produces no strobe, so that channel keeps its state.
    generate
        for (genvar c = 0; c < DMC_CHANS; c++)
        begin : g_chan
            dmc_chan_bit u_mask
            (
                .clk    (CLK_SYS),
                .nrst   (NRST),
                .set    (stb.mask_set[c]),
                .clr    (stb.mask_clr[c]),
                .hw_clr (1'b0),
                .q      (mask_q[c])
            );

            dmc_chan_bit u_enable
            (
                .clk    (CLK_SYS),
                .nrst   (NRST),
                .set    (stb.en_set[c]),
                .clr    (stb.en_clr[c]),
                .hw_clr (CYCLE_DONE[c]),
                .q      (en_q[c])
            );
        end
    endgenerate

    // Bus answer, controller enable and the gated request vector.
    always_comb
    begin
        next_st     = st;
        next_st.ack = access && mapped && !st.ack && !st.err;
        next_st.err = access && !mapped && !st.ack && !st.err;
        if (access && !WB_WE_I && !st.ack)
        begin
            // Reserved bits always come back as zero.
            next_st.dat = read_word(WB_ADR_I, mask_q, en_q);
        end
        if (write_now && hit(WB_ADR_I, DMC_ADR_CONFIG) && WB_SEL_I[0])
        begin
            next_st.ctrl_enable = WB_DAT_I[DMC_CFG_EN_POS];
        end
        // Requests pass only for enabled, unmasked channels of an enabled
        // controller. The extra register stage costs one cycle of latency
        // but keeps every output on a flip-flop.
        next_st.masked_req = req_level & ~mask_q & en_q & {DMC_CHANS{st.ctrl_enable}};
    end

    // Registers; everything clears on reset.
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign WB_DAT_O    = st.dat;
    assign WB_ACK_O    = st.ack;
    assign WB_ERR_O    = st.err;
    assign CHAN_ENABLE = en_q;
    assign MASKED_REQ  = st.masked_req;
    assign CTRL_ENABLE = st.ctrl_enable;

    // Acknowledge is one cycle wide and follows a fresh request by one cycle.
    ack_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("Acknowledge held longer than one cycle.");

    ack_latency_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (access && !WB_ACK_O && !WB_ERR_O) |=> (WB_ACK_O || WB_ERR_O))
        else $error("Bus request not answered in one cycle.");

    reserved_zero_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (WB_ACK_O && !WB_WE_I) |-> (WB_DAT_O[31:14] == 18'h00000))
        else $error("Reserved read bits not zero.");

    en_read_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (WB_ACK_O && !WB_WE_I && (hit(WB_ADR_I, DMC_ADR_EN_SET) || hit(WB_ADR_I, DMC_ADR_EN_CLR)))
        |-> (WB_DAT_O[13:0] == $past(CHAN_ENABLE)))
        else $error("Enable read did not return channel state.");

    en_set_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (write_now && hit(WB_ADR_I, DMC_ADR_EN_SET))
        |=> ((CHAN_ENABLE & $past(wr_bits[13:0])) == $past(wr_bits[13:0])))
        else $error("Enable set write did not enable channel.");

    en_clr_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (write_now && hit(WB_ADR_I, DMC_ADR_EN_CLR))
        |=> ((CHAN_ENABLE & $past(wr_bits[13:0])) == 14'h0000))
        else $error("Enable clear write did not disable channel.");

    mask_clr_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (write_now && hit(WB_ADR_I, DMC_ADR_MASK_CLR))
        |=> ((mask_q & $past(wr_bits[13:0])) == 14'h0000))
        else $error("Mask clear write did not unmask channel.");

    mask_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (write_now && hit(WB_ADR_I, DMC_ADR_MASK_CLR))
        |=> ((mask_q & ~$past(wr_bits[13:0])) == $past(mask_q & ~wr_bits[13:0])))
        else $error("Mask clear zero bits changed the mask.");

    mask_set_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (write_now && hit(WB_ADR_I, DMC_ADR_MASK_SET))
        |=> ((mask_q & $past(wr_bits[13:0])) == $past(wr_bits[13:0])))
        else $error("Mask set write did not mask channel.");

    done_clear_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (|(CYCLE_DONE & ~stb.en_set)) |=> ((CHAN_ENABLE & $past(CYCLE_DONE & ~stb.en_set)) == 14'h0000))
        else $error("Completed channel stayed enabled.");

    gate_off_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !CTRL_ENABLE |=> (MASKED_REQ == 14'h0000))
        else $error("Requests passed while controller disabled.");

endmodule

// File: rtl/dmc_req_sync.sv
// Synchroniser for the peripheral request pins.
// Assumes the pins are asynchronous to CLK_SYS.
`timescale 1ns/1ps
module dmc_req_sync
    import dmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [13:0] pin,
    output logic      [13:0] level
);

    dmc_sync_s st;
    dmc_sync_s next_st;

    // The first stage feeds only the second; a change is taken once stages two and three agree.
    always_comb
    begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level = st.q;

    // The filtered level only moves to a value both late stages hold.
    agree_level_a: assert property (@(posedge clk) disable iff (!nrst)
        (st.s2 == st.s3) |=> (st.q == $past(st.s3)))
        else $error("Request level did not follow agreeing stages.");

endmodule

// File: test/dmc_periph_model.sv
// Model of the peripherals that raise one request line per channel.
// Assumes the bench commands the wanted request levels on the system clock.
`timescale 1ns/1ps
module dmc_periph_model
    import dmc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [13:0] want,
    output logic      [13:0] req
);
    // Peripherals change their lines just after an edge, like real logic would.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            req <= '0;
        end
        else
        begin
            req <= want;
        end
    end
endmodule

// File: test/tb.sv
// Self-checking bench for the channel enable and request mask block.
// Assumes the design answers a Wishbone request with ACK or ERR.
`timescale 1ns/1ps
module tb
    import dmc_pkg::*;
;
    logic        CLK_SYS = 0;
    logic        NRST = 0;
    logic        WB_CYC_I = 0;
    logic        WB_STB_I = 0;
    logic        WB_WE_I = 0;
    logic [31:0] WB_ADR_I = '0;
    logic [3:0]  WB_SEL_I = 4'hf;
    logic [31:0] WB_DAT_I = '0;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK_O;
    logic        WB_ERR_O;
    logic [13:0] PERIPH_REQ;
    logic [13:0] CYCLE_DONE = '0;
    logic [13:0] CHAN_ENABLE;
    logic [13:0] MASKED_REQ;
    logic        CTRL_ENABLE;
    logic [13:0] want = '0;
    logic [31:0] q_t;
    logic        e_t;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc_n = 0;

    dmc_ctrl dmc_ctrl_inst (.CLK_SYS(CLK_SYS), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
        .PERIPH_REQ(PERIPH_REQ), .CYCLE_DONE(CYCLE_DONE), .CHAN_ENABLE(CHAN_ENABLE),
        .MASKED_REQ(MASKED_REQ), .CTRL_ENABLE(CTRL_ENABLE));
    dmc_periph_model dmc_periph_model_inst (.clk(CLK_SYS), .nrst(NRST), .want(want),
        .req(PERIPH_REQ));

    // A 20 ns period gives the 50 MHz system clock.
    always #10 CLK_SYS = ~CLK_SYS;

    // The whole run needs under two hundred cycles, so 5000 means a hang.
    always @(posedge CLK_SYS)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000)
        begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    // One classic cycle; dn is a completion pattern held for the whole cycle.
    // The acknowledge is sampled at the rising edge at which the design applies
    // the write, and the request is released only after that edge.
    task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d,
                       input logic [13:0] dn);
        @(posedge CLK_SYS);
        WB_CYC_I <= 1;
        WB_STB_I <= 1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        CYCLE_DONE <= dn;
        do @(posedge CLK_SYS); while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1);
        q_t = WB_DAT_O;
        e_t = WB_ERR_O;
        WB_CYC_I <= 0;
        WB_STB_I <= 0;
        CYCLE_DONE <= '0;
        @(posedge CLK_SYS);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, '0);
    endtask

    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, '0, '0);
        chk($sformatf("rd %h", a), e, q_t);
    endtask

    // Main sequence: reset, then register and pin scenarios in turn.
    initial
    begin
        repeat (12) @(posedge CLK_SYS);
        NRST <= 1;
        rc(DMC_ADR_EN_SET, 32'h0);
        rc(DMC_ADR_EN_CLR, 32'h0);
        rc(DMC_ADR_MASK_SET, 32'h0);
        rc(DMC_ADR_MASK_CLR, 32'h0);
        // Reserved upper bits are written as ones and must not read back.
        wr(DMC_ADR_EN_SET, 32'hffffc005);
        rc(DMC_ADR_EN_SET, 32'h5);
        wr(DMC_ADR_EN_SET, 32'h0);
        rc(DMC_ADR_EN_SET, 32'h5);
        wr(DMC_ADR_EN_CLR, 32'h1);
        rc(DMC_ADR_EN_CLR, 32'h4);
        wr(DMC_ADR_EN_CLR, 32'h0);
        rc(DMC_ADR_EN_SET, 32'h4);
        chk("chan_en", 32'h4, {18'h0, CHAN_ENABLE});
        wr(DMC_ADR_MASK_SET, 32'h3fff);
        rc(DMC_ADR_MASK_SET, 32'h3fff);
        wr(DMC_ADR_MASK_CLR, 32'h0);
        rc(DMC_ADR_MASK_SET, 32'h3fff);
        wr(DMC_ADR_MASK_CLR, 32'hffffc006);
        rc(DMC_ADR_MASK_SET, 32'h3ff9);
        // Channel 1 is unmasked but disabled, so only channel 2 may pass.
        want <= 14'h3fff;
        wr(DMC_ADR_CONFIG, 32'h1);
        repeat (6) @(posedge CLK_SYS);
        chk("ctrl_en", 32'h1, {31'h0, CTRL_ENABLE});
        chk("mreq", 32'h4, {18'h0, MASKED_REQ});
        // Masking the enabled channel must stop it; unmasking lets it through.
        wr(DMC_ADR_MASK_SET, 32'h4);
        repeat (3) @(posedge CLK_SYS);
        chk("mreq masked", 32'h0, {18'h0, MASKED_REQ});
        wr(DMC_ADR_MASK_CLR, 32'h4);
        repeat (3) @(posedge CLK_SYS);
        chk("mreq unmasked", 32'h4, {18'h0, MASKED_REQ});
        wr(DMC_ADR_CONFIG, 32'h0);
        repeat (3) @(posedge CLK_SYS);
        chk("mreq off", 32'h0, {18'h0, MASKED_REQ});
        @(posedge CLK_SYS);
        CYCLE_DONE <= 14'h4;
        @(posedge CLK_SYS);
        CYCLE_DONE <= '0;
        @(posedge CLK_SYS);
        chk("chan_en done", 32'h0, {18'h0, CHAN_ENABLE});
        rc(DMC_ADR_EN_SET, 32'h0);
        // Completion of channel 3 spans the enabling write; software wins.
        bus(1'b1, DMC_ADR_EN_SET, 32'h8, 14'h8);
        rc(DMC_ADR_EN_SET, 32'h8);
        // With byte lane 0 disabled only bits 13:8 of a written word may act.
        WB_SEL_I <= 4'he;
        wr(DMC_ADR_EN_SET, 32'h0303);
        wr(DMC_ADR_CONFIG, 32'h1);
        WB_SEL_I <= 4'hf;
        rc(DMC_ADR_EN_SET, 32'h308);
        chk("ctrl_en sel", 32'h0, {31'h0, CTRL_ENABLE});
        bus(1'b0, 32'h40010030, '0, '0);
        chk("unmapped err", 32'h1, {31'h0, e_t});
        results();
    end
endmodule
